// [shared/wdt_defs.vh]
// Purpose: constants of the watchdog timer core
// Assumes: 20 MHz system clock, 32-bit classic Wishbone slave
// Notes:   offsets are byte addresses, one aligned word each
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WDT_CLK_HZ 20000000
`define WDT_BASE_US 1000
`define WDT_TICK_CYC ((`WDT_CLK_HZ / 1000000) * `WDT_BASE_US)

// ----------------------------------------------------------------
// watchdog mode configuration codes
// ----------------------------------------------------------------
`define WDT_MODE_ON 2'h3
`define WDT_MODE_AWAKE 2'h2
`define WDT_MODE_SOFT 2'h1
`define WDT_MODE_OFF 2'h0

// ----------------------------------------------------------------
// period select: timeout = 2**period_select base ticks
// ----------------------------------------------------------------
`define WDT_PS_W 5
`define WDT_PS_MAX 5'h12
`define WDT_PS_RST 5'h0b
`define WDT_CNT_W 19

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define WDT_ADR_CTRL 8'h00
`define WDT_ADR_STATUS 8'h04
`define WDT_ADR_IRQ_STAT 8'h08
`define WDT_ADR_IRQ_MASK 8'h0c
`define WDT_ADR_COUNT 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_PS_LSB 1
`define WDT_CTRL_PS_MSB 5
`define WDT_ST_TIMEOUT_BIT 0
`define WDT_ST_PWRDN_BIT 1
`define WDT_ST_ACTIVE_BIT 2
`define WDT_ST_HOLD_BIT 3
`define WDT_IRQ_W 2
`define WDT_IRQ_RESET_BIT 0
`define WDT_IRQ_WAKE_BIT 1

`endif

// [hw/wdt_tick.v]
// Purpose: base time tick of the watchdog, one pulse per interval
// Assumes: runs from the system clock, stands in for the slow osc
// Notes:   restart on clear so each count starts a full interval
`timescale 1ns/100ps
`default_nettype none

module wdt_tick #(
    parameter TICK_CYCLES = 20000
) (
    input wire clk_i,
    input wire rst_i,
    input wire restart_i,
    output reg tick_o
);

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    reg [31:0] div_q;

    // count system clocks; pulse on the last one of each interval
    always @(posedge clk_i)
    begin
        if (rst_i || restart_i)
        begin
            div_q <= 32'h0000_0000;
            tick_o <= 1'b0;
        end
        else if (div_q == TICK_CYCLES - 1)
        begin
            div_q <= 32'h0000_0000;
            tick_o <= 1'b1;
        end
        else
        begin
            div_q <= div_q + 32'h0000_0001;
            tick_o <= 1'b0;
        end
    end

endmodule // wdt_tick
`default_nettype wire

// [hw/wdt_core.v]
// Purpose: watchdog timer with mode config, sleep and kick handling
// Assumes: core drives kick, sleep, reset and start-up timer levels
// Notes:   flags survive device resets, only power-on reset or a kick clears
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "wdt_defs.vh"

// What this block does
// - decode mode: on, awake only, soft, off
// - soft mode runs only while enable set
// - soft mode run state ignores sleep; sleep entry and exit still clear
// - period select gives 1 ms to 262144 ms
// - reset loads two second period
// - clear count on all listed events
// - sleep entry clears, then counting resumes
// - wake clears; crystal holds until start-up done
// - sleep timeout wakes instead of resetting
// - timeout sets timeout flag; sleep entry sets powerdown flag
// - awake-only mode stops count in sleep
// - soft mode disabled keeps count cleared
// - osc divider changes leave count alone
// - count from independent one millisecond tick
module wdt_core #(
    parameter TICK_CYCLES = `WDT_TICK_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire dev_rst_i,
    input wire [1:0] watchdog_mode_config_i,
    input wire crystal_clock_i,
    input wire kick_instruction_i,
    input wire sleep_i,
    input wire osc_fail_i,
    input wire osc_startup_timer_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wdt_reset_o,
    output reg wake_o,
    output reg timeout_flag_o,
    output reg powerdown_flag_o,
    output wire irq_o
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg [1:0] mode_s1_q;
    reg [1:0] mode_q;
    reg xtal_s1_q;
    reg xtal_q;
    reg sleep_prev_q;
    reg ost_prev_q;
    reg hold_q;
    reg soft_watchdog_enable_q;
    reg [`WDT_PS_W-1:0] period_select_q;
    reg [`WDT_CNT_W-1:0] cnt_q;
    reg [`WDT_IRQ_W-1:0] irq_stat_q;
    reg [`WDT_IRQ_W-1:0] irq_mask_q;
    reg active;
    wire sleep_enter;
    wire sleep_exit;
    wire clr;
    wire tick;
    wire expire;
    wire [`WDT_CNT_W-1:0] limit;
    wire [`WDT_PS_W-1:0] ps_eff;
    wire wb_req;
    wire wr;
    wire [`WDT_IRQ_W-1:0] irq_set;
    wire [`WDT_IRQ_W-1:0] irq_w1c;

    // ----------------------------------------------------------------
    // input synchronisers for the configuration pins
    // ----------------------------------------------------------------
    // static strap-like levels, still two flops before use
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_s1_q <= 2'h0;
            mode_q <= 2'h0;
            xtal_s1_q <= 1'b0;
            xtal_q <= 1'b0;
        end
        else
        begin
            mode_s1_q <= watchdog_mode_config_i;
            mode_q <= mode_s1_q;
            xtal_s1_q <= crystal_clock_i;
            xtal_q <= xtal_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    // whether the watchdog runs in the present device state
    always @*
    begin
        case (mode_q)
            `WDT_MODE_ON: active = 1'b1;
            `WDT_MODE_AWAKE: active = ~sleep_i;
            // sleep plays no part here
            `WDT_MODE_SOFT: active = soft_watchdog_enable_q;
            default: active = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // sleep and start-up tracking
    // ----------------------------------------------------------------
    assign sleep_enter = sleep_i & ~sleep_prev_q;
    assign sleep_exit = ~sleep_i & sleep_prev_q;

    // wake with a crystal clock holds the count until start-up ends
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sleep_prev_q <= 1'b0;
            ost_prev_q <= 1'b0;
            hold_q <= 1'b0;
        end
        else
        begin
            sleep_prev_q <= sleep_i;
            ost_prev_q <= osc_startup_timer_i;
            if (sleep_exit && xtal_q)
                hold_q <= 1'b1;
            else if (ost_prev_q && !osc_startup_timer_i)
                hold_q <= 1'b0;
            else if (dev_rst_i)
                hold_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // count clear and expiry
    // ----------------------------------------------------------------
    // every clearing event; disabled covers soft mode with enable low
    assign clr = rst_i | dev_rst_i | kick_instruction_i
        | sleep_enter | sleep_exit | osc_fail_i
        | ~active | osc_startup_timer_i | hold_q;

    // clamp out-of-range selections to the longest period
    assign ps_eff = (period_select_q > `WDT_PS_MAX) ? `WDT_PS_MAX
        : period_select_q;
    // terminal count is 2**select - 1 base ticks
    assign limit = {`WDT_CNT_W{1'b1}}
        >> (`WDT_CNT_W - ps_eff);
    assign expire = active & ~clr & tick & (cnt_q == limit);

    // base tick, independent of the system oscillator divider
    wdt_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(clr),
        .tick_o(tick)
    );

    // the count; after sleep entry it resumes if still active
    always @(posedge clk_i)
    begin
        if (clr || expire)
            cnt_q <= {`WDT_CNT_W{1'b0}};
        else if (tick)
            cnt_q <= cnt_q + 1'b1;
    end

    // ----------------------------------------------------------------
    // timeout actions and status flags
    // ----------------------------------------------------------------
    // timeout in sleep wakes, timeout awake resets the device
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wdt_reset_o <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            wdt_reset_o <= expire & ~sleep_i;
            wake_o <= expire & sleep_i;
        end
    end

    // flags only cleared by power-on reset or a kick
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timeout_flag_o <= 1'b0;
            powerdown_flag_o <= 1'b0;
        end
        else
        begin
            if (expire)
                timeout_flag_o <= 1'b1;
            else if (kick_instruction_i)
                timeout_flag_o <= 1'b0;
            if (sleep_enter)
                powerdown_flag_o <= 1'b1;
            else if (kick_instruction_i)
                powerdown_flag_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = wb_req & wb_we_i & wb_sel_i[0];

    // control register; device resets restore the default period
    always @(posedge clk_i)
    begin
        if (rst_i || dev_rst_i)
        begin
            soft_watchdog_enable_q <= 1'b0;
            period_select_q <= `WDT_PS_RST;
        end
        else if (wr && wb_adr_i == `WDT_ADR_CTRL)
        begin
            soft_watchdog_enable_q <= wb_dat_i[`WDT_CTRL_EN_BIT];
            period_select_q <=
                wb_dat_i[`WDT_CTRL_PS_MSB:`WDT_CTRL_PS_LSB];
        end
    end

    // sticky interrupt status, set wins over write-one-to-clear
    assign irq_set = {wake_o, wdt_reset_o};
    assign irq_w1c = (wr && wb_adr_i == `WDT_ADR_IRQ_STAT)
        ? wb_dat_i[`WDT_IRQ_W-1:0] : {`WDT_IRQ_W{1'b0}};

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat_q <= {`WDT_IRQ_W{1'b0}};
            irq_mask_q <= {`WDT_IRQ_W{1'b0}};
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_set;
            if (wr && wb_adr_i == `WDT_ADR_IRQ_MASK)
                irq_mask_q <= wb_dat_i[`WDT_IRQ_W-1:0];
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    // one wait state ack, read data registered; unmapped reads zero
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_adr_i == `WDT_ADR_CTRL)
            begin
                wb_dat_o[`WDT_CTRL_EN_BIT] <= soft_watchdog_enable_q;
                wb_dat_o[`WDT_CTRL_PS_MSB:`WDT_CTRL_PS_LSB] <=
                    period_select_q;
            end
            else if (wb_adr_i == `WDT_ADR_STATUS)
            begin
                wb_dat_o[`WDT_ST_TIMEOUT_BIT] <= timeout_flag_o;
                wb_dat_o[`WDT_ST_PWRDN_BIT] <= powerdown_flag_o;
                wb_dat_o[`WDT_ST_ACTIVE_BIT] <= active;
                wb_dat_o[`WDT_ST_HOLD_BIT] <= hold_q;
            end
            else if (wb_adr_i == `WDT_ADR_IRQ_STAT)
                wb_dat_o[`WDT_IRQ_W-1:0] <= irq_stat_q;
            else if (wb_adr_i == `WDT_ADR_IRQ_MASK)
                wb_dat_o[`WDT_IRQ_W-1:0] <= irq_mask_q;
            else if (wb_adr_i == `WDT_ADR_COUNT)
                wb_dat_o[`WDT_CNT_W-1:0] <= cnt_q;
        end
    end

endmodule // wdt_core
`default_nettype wire

// [tb/wdt_sva.sv]
// Purpose: port checks of wdt_core
// Assumes: one clock, sync reset
// Notes:   bound below to every wdt_core
`timescale 1ns/100ps
`default_nettype none
`include "wdt_defs.vh"
module wdt_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] watchdog_mode_config_i,
    input wire logic kick_instruction_i,
    input wire logic sleep_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wdt_reset_o,
    input wire logic wake_o,
    input wire logic timeout_flag_o,
    input wire logic powerdown_flag_o
);
    // ----
    // checks
    // ----
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    AST_EV_PULSE:
        assert property (wdt_reset_o || wake_o |=> !wdt_reset_o && !wake_o)
        else $error("event too long");
    AST_EV_ONE:
        assert property (!(wdt_reset_o && wake_o))
        else $error("reset and wake");
    AST_FLAG:
        assert property (wdt_reset_o || wake_o |-> timeout_flag_o)
        else $error("timeout flag low");
    AST_WAKE_SLEEP:
        assert property (wake_o |-> $past(sleep_i))
        else $error("wake while awake");
    AST_RESET_AWAKE:
        assert property (wdt_reset_o |-> !$past(sleep_i))
        else $error("reset in sleep");
    AST_OFF:
        assert property ((watchdog_mode_config_i == `WDT_MODE_OFF)[*5]
            |-> !wdt_reset_o && !wake_o)
        else $error("event while off");
    AST_KICK:
        assert property (kick_instruction_i[*3] |-> !wdt_reset_o && !wake_o)
        else $error("event while kicked");
    AST_PD_SET:
        assert property ($rose(sleep_i) |-> ##[1:2] powerdown_flag_o)
        else $error("powerdown flag low");
    AST_AWAKE_ONLY:
        assert property ((watchdog_mode_config_i == `WDT_MODE_AWAKE
            && sleep_i)[*5] |-> !wake_o)
        else $error("wake in awake mode");
endmodule // wdt_sva
bind wdt_core wdt_sva i_wdt_sva (
    .clk_i(clk_i), .rst_i(rst_i),
    .watchdog_mode_config_i(watchdog_mode_config_i),
    .kick_instruction_i(kick_instruction_i), .sleep_i(sleep_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wdt_reset_o(wdt_reset_o), .wake_o(wake_o),
    .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o));
`default_nettype wire

// [tb/wdt_cpu_model.sv]
// Purpose: processor core beside the watchdog
// Assumes: sleeps on a rising request
// Notes:   leaves sleep on wake or request drop
`timescale 1ns/100ps
`default_nettype none
module wdt_cpu_model (
    input wire logic clk_i,
    input wire logic kick_req_i,
    input wire logic sleep_req_i,
    input wire logic wake_i,
    input wire logic wdt_reset_i,
    input wire logic crystal_i,
    output logic kick_o = 1'b0,
    output logic sleep_o = 1'b0,
    output logic ost_o,
    output logic dev_rst_o = 1'b0
);
    logic req_q = 1'b0;
    int ost_n = 0;
    // ----
    // core
    // ----
    assign ost_o = ost_n > 0;
    // watchdog reset restarts the core; crystal wake runs start-up
    always @(posedge clk_i)
    begin
        kick_o <= kick_req_i;
        dev_rst_o <= wdt_reset_i;
        req_q <= sleep_req_i;
        sleep_o <= sleep_req_i && !wake_i && (sleep_o || !req_q);
        if (sleep_o && (wake_i || !sleep_req_i) && crystal_i)
            ost_n <= 20;
        else if (ost_n > 0)
            ost_n <= ost_n - 1;
    end
endmodule // wdt_cpu_model
`default_nettype wire

// [tb/tb_wdt_core.sv]
// Purpose: self-checking bench of wdt_core
// Assumes: tick of four clocks
// Notes:   a monitor pairs results with queued notes
`timescale 1ns/100ps
`default_nettype none
`include "wdt_defs.vh"
module tb_wdt_core;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    localparam logic [31:0] NUL = 32'h0000_0000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic xtal = 1'b0, fail = 1'b0, kreq = 1'b0, sreq = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic dev_rst, kick, sleep, osc_startup_timer, ack, wrst, wake, irq;
    logic tflag, pflag;
    logic [63:0] rq[$];
    logic [1:0] eq[$];
    int n_mismatch = 0;
    int tests_run = 0;
    // ----
    // clock, design and core model
    // ----
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    wdt_core #(.TICK_CYCLES(4)) i_wdt_core (
        .clk_i(clk_i), .rst_i(rst_i), .dev_rst_i(dev_rst),
        .watchdog_mode_config_i(mode), .crystal_clock_i(xtal),
        .kick_instruction_i(kick), .sleep_i(sleep), .osc_fail_i(fail),
        .osc_startup_timer_i(osc_startup_timer), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wdt_reset_o(wrst),
        .wake_o(wake), .timeout_flag_o(tflag), .powerdown_flag_o(pflag),
        .irq_o(irq));
    wdt_cpu_model i_wdt_cpu_model (.clk_i(clk_i), .kick_req_i(kreq),
        .sleep_req_i(sreq), .wake_i(wake), .wdt_reset_i(wrst),
        .crystal_i(xtal), .kick_o(kick), .sleep_o(sleep), .ost_o(osc_startup_timer),
        .dev_rst_o(dev_rst));
    // ----
    // tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_ev(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0000_0000, got}, {30'h0000_0000, exp});
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] m);
        int i;
        if (!w)
            rq.push_back({m, d & m});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 20 && ack !== 1'b1; i++)
            @(posedge clk_i);
        chk(ack, 32'h0000_0001);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic ev(input logic [1:0] e, output int n);
        eq.push_back(e);
        for (n = 0; n < 400 && eq.size() > 0; n++)
            @(posedge clk_i);
        if (eq.size() > 0)
            chk_ev(2'h0, eq.pop_front());
        repeat (3) @(posedge clk_i);
    endtask
    task automatic kick3(input int gap);
        kreq <= 1'b1;
        repeat (3) @(posedge clk_i);
        kreq <= 1'b0;
        repeat (gap) @(posedge clk_i);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // monitor: each read answer and event meets the oldest note
    always @(posedge clk_i)
    begin
        if (ack && !we && rq.size() > 0)
        begin
            chk(rdat & rq[0][63:32], rq[0][31:0]);
            void'(rq.pop_front());
        end
        if (wrst || wake)
            chk_ev({wake, wrst}, eq.size() > 0 ? eq.pop_front() : 2'h0);
    end
    // watchdog against a hang
    initial
    begin
        repeat (10000) @(posedge clk_i);
        n_mismatch++;
        print_verdict();
    end
    // main sequence
    initial
    begin
        int n, k;
        void'($urandom(60586));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(0, `WDT_ADR_CTRL, 32'h0000_0016, ALL);
        bus(1, 8'h20, $urandom, ALL);
        bus(0, 8'h20, NUL, ALL);
        bus(1, `WDT_ADR_CTRL, NUL, ALL);
        repeat (60) @(posedge clk_i);
        mode <= `WDT_MODE_ON;
        ev(2'h1, n);
        bus(0, `WDT_ADR_CTRL, 32'h0000_0016, 32'h0000_003e);
        mode <= `WDT_MODE_SOFT;
        bus(1, `WDT_ADR_CTRL, NUL, ALL);
        repeat (60) @(posedge clk_i);
        bus(1, `WDT_ADR_CTRL, 32'h0000_0001, ALL);
        ev(2'h1, n);
        done("modes");
        // soft mode counts on in sleep; a crystal wake holds the count
        for (k = 0; k < 2; k++)
        begin
            mode <= k ? `WDT_MODE_ON : `WDT_MODE_SOFT;
            xtal <= k[0];
            sreq <= 1'b1;
            repeat (4) @(posedge clk_i);
            bus(1, `WDT_ADR_CTRL, 32'h0000_0001, ALL);
            eq.push_back(2'h2);
            for (n = 0; n < 99 && eq.size() > 0; n++)
                @(posedge clk_i);
            sreq <= 1'b0;
            @(posedge clk_i);
            for (n = 0; n < 50 && osc_startup_timer === 1'b1; n++)
                @(posedge clk_i);
            ev(2'h1, n);
        end
        bus(0, `WDT_ADR_STATUS, 32'h0000_0003, 32'h0000_0003);
        chk({30'h0000_0000, pflag, tflag}, 32'h0000_0003);
        mode <= `WDT_MODE_AWAKE;
        xtal <= 1'b0;
        sreq <= 1'b1;
        repeat (4) @(posedge clk_i);
        bus(1, `WDT_ADR_CTRL, NUL, ALL);
        repeat (60) @(posedge clk_i);
        sreq <= 1'b0;
        ev(2'h1, n);
        done("sleep");
        mode <= `WDT_MODE_ON;
        bus(1, `WDT_ADR_CTRL, 32'h0000_0002, ALL);
        for (k = 0; k < 20; k++)
            kick3(1 + $urandom % 3);
        fail <= 1'b1;
        repeat (40) @(posedge clk_i);
        fail <= 1'b0;
        ev(2'h1, n);
        for (k = 0; k < 4; k++)
        begin
            kreq <= 1'b1;
            bus(1, `WDT_ADR_CTRL, k << 1, ALL);
            kreq <= 1'b0;
            ev(2'h1, n);
            chk(n >= 4 << k && n <= (4 << k) + 6, 32'h0000_0001);
        end
        done("clears and periods");
        bus(0, `WDT_ADR_IRQ_STAT, 32'h0000_0003, ALL);
        bus(1, `WDT_ADR_IRQ_MASK, 32'h0000_0002, ALL);
        chk(irq, 32'h0000_0001);
        bus(1, `WDT_ADR_IRQ_STAT, 32'h0000_0002, ALL);
        chk(irq, NUL);
        bus(1, `WDT_ADR_IRQ_MASK, 32'h0000_0001, ALL);
        chk(irq, 32'h0000_0001);
        bus(1, `WDT_ADR_IRQ_STAT, 32'h0000_0001, ALL);
        bus(0, `WDT_ADR_IRQ_STAT, NUL, ALL);
        chk(irq, NUL);
        done("interrupt");
        print_verdict();
    end
endmodule // tb_wdt_core
`default_nettype wire
